// File: logic/rcpt_pkg.sv
// constants for the real-time counter and periodic tick block
package rcpt_pkg;
	// register indexes; byte address is four times the index
	localparam logic [5:0] IDX_DEBUG_CONTROL = 6'h05;
	localparam logic [5:0] IDX_ERR_CORRECTION = 6'h06;
	localparam logic [5:0] IDX_SOURCE_SELECT = 6'h07;
	localparam logic [5:0] IDX_COUNT_LO = 6'h08;
	localparam logic [5:0] IDX_COUNT_HI = 6'h09;
	localparam logic [5:0] IDX_LIMIT_LO = 6'h0a;
	localparam logic [5:0] IDX_LIMIT_HI = 6'h0b;
	localparam logic [5:0] IDX_MATCH_LO = 6'h0c;
	localparam logic [5:0] IDX_MATCH_HI = 6'h0d;
	localparam logic [5:0] IDX_TICK_CONTROL = 6'h10;
	localparam logic [5:0] IDX_TICK_SYNC = 6'h11;
	localparam logic [5:0] IDX_TICK_IRQ_EN = 6'h12;
	localparam logic [5:0] IDX_TICK_IRQ_FLAG = 6'h13;
	localparam logic [5:0] IDX_TICK_HALT = 6'h15;
	localparam logic [5:0] IDX_COUNT_CONTROL = 6'h18;
	localparam logic [5:0] IDX_COUNT_SYNC = 6'h19;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h1a;
	localparam logic [5:0] IDX_IRQ_CLEAR = 6'h1b;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h1c;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_LIMIT = 16'hffff;
	localparam logic [15:0] RST_MATCH = 16'h0000;
	// field positions
	localparam int RUN_HALTED_BIT = 0;
	localparam int SIGN_BIT = 7;
	localparam int TICK_EN_BIT = 0;
	localparam int TICK_PER_LSB = 3;
	localparam int CNT_EN_BIT = 0;
	localparam int TRIM_EN_BIT = 2;
	localparam int PRESC_LSB = 3;
	localparam int BUSY_CNT_BIT = 1;
	localparam int BUSY_LIM_BIT = 2;
	// irq status layout
	localparam int IRQ_WRAP = 0;
	localparam int IRQ_MATCH = 1;
	localparam int IRQ_TICK = 2;
	localparam int IRQ_W = 3;
	// source select codes
	localparam logic [1:0] SRC_INT32K = 2'h0;
	localparam logic [1:0] SRC_INT1K = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	// tick interval codes
	localparam logic [3:0] TICK_OFF = 4'h0;
	localparam logic [3:0] TICK_RSVD = 4'hf;
	// domain crossing latency in rtc cycles
	localparam logic [1:0] SYNC_RTC_CYCLES = 2'h2;
	// correction interval in rtc cycles and slot spacing as a power-of-two exponent of rtc cycles
	localparam int CORR_INTERVAL = 1000000;
	localparam logic [19:0] CORR_LAST = 20'(CORR_INTERVAL - 1);
	localparam int CORR_SLOT_BITS = 12;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rcpt_pkg

// File: logic/rcpt_sync.sv
// two-flop synchronisers with rising edge pulses
`timescale 1ns/1ps
module rcpt_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// asynchronous inputs
	input wire logic [W-1:0] d,
	// synchronised level and edge
	output logic [W-1:0] q,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_r, s2_r, s3_r;

	// rise looks only at the second and third flops
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign q = s2_r;
	assign rise = s2_r & ~s3_r;
endmodule : rcpt_sync

// File: logic/rcpt_tick.sv
// periodic tick timer counting rtc cycles
`timescale 1ns/1ps
module rcpt_tick
	import rcpt_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// control
	input wire logic rtc_tick,
	input wire logic run,
	input wire logic [3:0] interval,
	// event
	output logic tick_event
);
	logic [14:0] div_r, div_nxt;
	logic [14:0] last;
	logic live;

	always_comb begin
		live = (interval != TICK_OFF) && (interval != TICK_RSVD);
		last = 15'((16'h0001 << (interval + 4'h1)) - 16'h0001);
		div_nxt = div_r;
		tick_event = 1'b0;
		if (!run || !live) begin
			div_nxt = '0;
		end else if (rtc_tick) begin
			if (div_r >= last) begin
				div_nxt = '0;
				tick_event = 1'b1;
			end else begin
				div_nxt = div_r + 15'h0001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end
endmodule : rcpt_tick

// File: logic/rcpt_top.sv
// real-time counter with periodic tick, axi4-lite register slave
`timescale 1ns/1ps
module rcpt_top
	import rcpt_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// axi4-lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// clock sources and debug halt pins
	input wire logic internal_32k_osc,
	input wire logic internal_1k_tap,
	input wire logic crystal_32k_source,
	input wire logic external_clock_pin,
	input wire logic cpu_halted,
	// interrupts
	output logic tick_irq,
	output logic irq
);
	// synchronised pins
	logic [4:0] pin_q, pin_rise;
	rcpt_sync #(.W(5)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.d({cpu_halted, external_clock_pin, crystal_32k_source, internal_1k_tap, internal_32k_osc}),
		.q(pin_q),
		.rise(pin_rise)
	);

	// software registers
	logic [7:0] dbg_r, dbg_nxt, trim_r, trim_nxt, src_r, src_nxt;
	logic [7:0] tctl_r, tctl_nxt, tctl_act_r, tctl_act_nxt;
	logic tie_r, tie_nxt, thalt_r, thalt_nxt;
	logic [7:0] cctl_r, cctl_nxt;
	logic [15:0] cnt_wr_r, cnt_wr_nxt, lim_wr_r, lim_wr_nxt, lim_act_r, lim_act_nxt;
	logic [15:0] match_r, match_nxt;
	logic [IRQ_W-1:0] ien_r, ien_nxt, ist_r, ist_nxt;
	// crossing state: pending flag and rtc cycle count
	logic cp_r, cp_nxt, lp_r, lp_nxt, tp_r, tp_nxt;
	logic [1:0] cc_r, cc_nxt, lc_r, lc_nxt, tc_r, tc_nxt;
	// counting state
	logic [15:0] cnt_r, cnt_nxt, pre_r, pre_nxt;
	logic [19:0] ppm_r, ppm_nxt;
	logic [6:0] corr_r, corr_nxt;
	// bus state
	logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [5:0] awi_r, awi_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic wb_r, wb_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;

	logic rtc_tick, halted, cnt_run, cnt_step, wrap_ev, match_ev, tick_ev;
	logic do_wr, wr_ok, rd_ok, corr_slot;
	logic [7:0] rd_byte;
	logic [16:0] pre_sum;
	logic [15:0] pre_last;
	logic [1:0] pre_inc;

	// source choice; only rising edges of the picked source count
	always_comb begin
		unique case (src_r[1:0])
			SRC_INT32K: rtc_tick = pin_rise[0];
			SRC_INT1K: rtc_tick = pin_rise[1];
			SRC_XTAL: rtc_tick = pin_rise[2];
			SRC_EXT: rtc_tick = pin_rise[3];
		endcase
	end

	assign halted = pin_q[4];

	rcpt_tick u_tick (
		.clock(clock),
		.nrst(nrst),
		.rtc_tick(rtc_tick),
		.run(tctl_act_r[TICK_EN_BIT] && !(halted && !thalt_r)),
		.interval(tctl_act_r[TICK_PER_LSB +: 4]),
		.tick_event(tick_ev)
	);

	// bus handshakes: one write and one read in flight
	assign awready = !aw_h_r && !bv_r;
	assign wready = !w_h_r && !bv_r;
	assign arready = !rv_r;
	assign bvalid = bv_r;
	assign bresp = br_r;
	assign rvalid = rv_r;
	assign rresp = rr_r;
	assign rdata = rd_r;
	assign do_wr = aw_h_r && w_h_r && !bv_r;

	function automatic logic idx_ok(input logic [5:0] i);
		idx_ok = (i >= IDX_DEBUG_CONTROL && i <= IDX_TICK_IRQ_FLAG && i != 6'h0e && i != 6'h0f)
			|| i == IDX_TICK_HALT || (i >= IDX_COUNT_CONTROL && i <= IDX_IRQ_ENABLE);
	endfunction : idx_ok

	always_comb begin
		aw_h_nxt = aw_h_r;
		w_h_nxt = w_h_r;
		awi_nxt = awi_r;
		wd_nxt = wd_r;
		wb_nxt = wb_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		if (awvalid && awready) begin
			aw_h_nxt = 1'b1;
			awi_nxt = awaddr[7:2];
		end
		if (wvalid && wready) begin
			w_h_nxt = 1'b1;
			wd_nxt = wdata[7:0];
			wb_nxt = wstrb[0];
		end
		wr_ok = do_wr && wb_r && idx_ok(awi_r);
		if (do_wr) begin
			aw_h_nxt = 1'b0;
			w_h_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = idx_ok(awi_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (bv_r && bready) begin
			bv_nxt = 1'b0;
		end
	end

	// read mux; unused bits read zero
	always_comb begin
		rd_byte = 8'h00;
		unique case (araddr[7:2])
			IDX_DEBUG_CONTROL: rd_byte = dbg_r;
			IDX_ERR_CORRECTION: rd_byte = trim_r;
			IDX_SOURCE_SELECT: rd_byte = src_r;
			IDX_COUNT_LO: rd_byte = cnt_r[7:0];
			IDX_COUNT_HI: rd_byte = cnt_r[15:8];
			IDX_LIMIT_LO: rd_byte = lim_wr_r[7:0];
			IDX_LIMIT_HI: rd_byte = lim_wr_r[15:8];
			IDX_MATCH_LO: rd_byte = match_r[7:0];
			IDX_MATCH_HI: rd_byte = match_r[15:8];
			IDX_TICK_CONTROL: rd_byte = tctl_r;
			IDX_TICK_SYNC: rd_byte = {7'h00, tp_r};
			IDX_TICK_IRQ_EN: rd_byte = {7'h00, tie_r};
			IDX_TICK_IRQ_FLAG: rd_byte = {7'h00, ist_r[IRQ_TICK]};
			IDX_TICK_HALT: rd_byte = {7'h00, thalt_r};
			IDX_COUNT_CONTROL: rd_byte = cctl_r;
			IDX_COUNT_SYNC: rd_byte = {5'h00, lp_r, cp_r, 1'b0};
			IDX_IRQ_STATUS: rd_byte = {5'h00, ist_r};
			IDX_IRQ_ENABLE: rd_byte = {5'h00, ien_r};
			default: rd_byte = 8'h00;
		endcase
		rd_ok = idx_ok(araddr[7:2]) && araddr[7:2] != IDX_IRQ_CLEAR;
		rv_nxt = rv_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		if (arvalid && arready) begin
			rv_nxt = 1'b1;
			rr_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
			rd_nxt = {24'h000000, rd_byte};
		end else if (rv_r && rready) begin
			rv_nxt = 1'b0;
		end
	end

	// register writes and crossing into the rtc time base
	always_comb begin
		dbg_nxt = dbg_r;
		trim_nxt = trim_r;
		src_nxt = src_r;
		tctl_nxt = tctl_r;
		tie_nxt = tie_r;
		thalt_nxt = thalt_r;
		cctl_nxt = cctl_r;
		cnt_wr_nxt = cnt_wr_r;
		lim_wr_nxt = lim_wr_r;
		match_nxt = match_r;
		ien_nxt = ien_r;
		cp_nxt = cp_r;
		lp_nxt = lp_r;
		tp_nxt = tp_r;
		cc_nxt = cc_r;
		lc_nxt = lc_r;
		tc_nxt = tc_r;
		tctl_act_nxt = tctl_act_r;
		lim_act_nxt = lim_act_r;
		// pending writes land on the second rtc cycle
		if (rtc_tick && cp_r) begin
			cc_nxt = cc_r + 2'h1;
			if (cc_r + 2'h1 == SYNC_RTC_CYCLES) cp_nxt = 1'b0;
		end
		if (rtc_tick && lp_r) begin
			lc_nxt = lc_r + 2'h1;
			if (lc_r + 2'h1 == SYNC_RTC_CYCLES) begin
				lp_nxt = 1'b0;
				lim_act_nxt = lim_wr_r;
			end
		end
		if (rtc_tick && tp_r) begin
			tc_nxt = tc_r + 2'h1;
			if (tc_r + 2'h1 == SYNC_RTC_CYCLES) begin
				tp_nxt = 1'b0;
				tctl_act_nxt = tctl_r;
			end
		end
		// writes during busy restart the transfer; software should wait
		if (wr_ok) begin
			unique case (awi_r)
				IDX_DEBUG_CONTROL: dbg_nxt = {7'h00, wd_r[RUN_HALTED_BIT]};
				IDX_ERR_CORRECTION: trim_nxt = wd_r;
				IDX_SOURCE_SELECT: src_nxt = {6'h00, wd_r[1:0]};
				IDX_COUNT_LO, IDX_COUNT_HI: begin
					if (awi_r == IDX_COUNT_LO) cnt_wr_nxt = {cnt_r[15:8], wd_r};
					else cnt_wr_nxt = {wd_r, cnt_r[7:0]};
					cp_nxt = 1'b1;
					cc_nxt = 2'h0;
				end
				IDX_LIMIT_LO, IDX_LIMIT_HI: begin
					if (awi_r == IDX_LIMIT_LO) lim_wr_nxt = {lim_wr_r[15:8], wd_r};
					else lim_wr_nxt = {wd_r, lim_wr_r[7:0]};
					lp_nxt = 1'b1;
					lc_nxt = 2'h0;
				end
				IDX_MATCH_LO: match_nxt = {match_r[15:8], wd_r};
				IDX_MATCH_HI: match_nxt = {wd_r, match_r[7:0]};
				IDX_TICK_CONTROL: begin
					tctl_nxt = {1'b0, wd_r[6:3], 2'b00, wd_r[TICK_EN_BIT]};
					tp_nxt = 1'b1;
					tc_nxt = 2'h0;
				end
				IDX_TICK_IRQ_EN: tie_nxt = wd_r[0];
				IDX_TICK_HALT: thalt_nxt = wd_r[RUN_HALTED_BIT];
				IDX_COUNT_CONTROL: cctl_nxt = {1'b0, wd_r[6:2], 1'b0, wd_r[CNT_EN_BIT]};
				IDX_IRQ_ENABLE: begin
					ien_nxt = wd_r[IRQ_W-1:0];
					tie_nxt = wd_r[IRQ_TICK];
				end
				default: ;
			endcase
		end
		ien_nxt[IRQ_TICK] = tie_nxt;
	end

	// prescaler, correction and counter
	always_comb begin
		cnt_run = cctl_r[CNT_EN_BIT] && !(halted && !dbg_r[RUN_HALTED_BIT]);
		pre_last = 16'((17'h00001 << cctl_r[PRESC_LSB +: 4]) - 17'h00001);
		corr_slot = (ppm_r[CORR_SLOT_BITS-1:0] == '0) && (corr_r != 7'h00) && cctl_r[TRIM_EN_BIT];
		pre_inc = 2'h1;
		ppm_nxt = ppm_r;
		corr_nxt = corr_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		cnt_step = 1'b0;
		wrap_ev = 1'b0;
		match_ev = 1'b0;
		if (cnt_run && rtc_tick) begin
			// corrections spread over slots within each million-cycle interval
			if (ppm_r == CORR_LAST) begin
				ppm_nxt = '0;
				corr_nxt = trim_r[6:0];
			end else begin
				ppm_nxt = ppm_r + 20'h00001;
			end
			if (corr_slot) begin
				corr_nxt = corr_r - 7'h01;
				pre_inc = trim_r[SIGN_BIT] ? 2'h2 : 2'h0;
			end
			pre_sum = {1'b0, pre_r} + {15'h0000, pre_inc};
			if (pre_sum > {1'b0, pre_last}) begin
				cnt_step = 1'b1;
				pre_nxt = 16'(pre_sum - {1'b0, pre_last} - 17'h00001);
			end else begin
				pre_nxt = pre_sum[15:0];
			end
		end else begin
			pre_sum = {1'b0, pre_r};
		end
		if (cnt_step) begin
			if (cnt_r == lim_act_r) begin
				cnt_nxt = '0;
				wrap_ev = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
			match_ev = (cnt_nxt == match_r);
		end
		if (rtc_tick && cp_r && cc_r + 2'h1 == SYNC_RTC_CYCLES) begin
			cnt_nxt = cnt_wr_r;
			pre_nxt = '0;
		end
	end

	// sticky flags; a new event wins over a clear in the same cycle
	always_comb begin
		ist_nxt = ist_r;
		if (wr_ok && awi_r == IDX_IRQ_CLEAR) ist_nxt = ist_r & ~wd_r[IRQ_W-1:0];
		if (wr_ok && awi_r == IDX_TICK_IRQ_FLAG && wd_r[0]) ist_nxt[IRQ_TICK] = 1'b0;
		if (wrap_ev) ist_nxt[IRQ_WRAP] = 1'b1;
		if (match_ev) ist_nxt[IRQ_MATCH] = 1'b1;
		if (tick_ev) ist_nxt[IRQ_TICK] = 1'b1;
	end

	assign tick_irq = ist_r[IRQ_TICK] && tie_r;
	assign irq = |(ist_r & ien_r);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			dbg_r <= RST_BYTE;
			trim_r <= RST_BYTE;
			src_r <= RST_BYTE;
			tctl_r <= RST_BYTE;
			tctl_act_r <= RST_BYTE;
			tie_r <= 1'b0;
			thalt_r <= 1'b0;
			cctl_r <= RST_BYTE;
			cnt_wr_r <= RST_COUNT;
			lim_wr_r <= RST_LIMIT;
			lim_act_r <= RST_LIMIT;
			match_r <= RST_MATCH;
			ien_r <= '0;
			ist_r <= '0;
			cp_r <= 1'b0;
			lp_r <= 1'b0;
			tp_r <= 1'b0;
			cc_r <= 2'h0;
			lc_r <= 2'h0;
			tc_r <= 2'h0;
			cnt_r <= RST_COUNT;
			pre_r <= '0;
			ppm_r <= '0;
			corr_r <= '0;
			aw_h_r <= 1'b0;
			w_h_r <= 1'b0;
			awi_r <= '0;
			wd_r <= 8'h00;
			wb_r <= 1'b0;
			bv_r <= 1'b0;
			br_r <= RESP_OKAY;
			rv_r <= 1'b0;
			rr_r <= RESP_OKAY;
			rd_r <= 32'h00000000;
		end else begin
			dbg_r <= dbg_nxt;
			trim_r <= trim_nxt;
			src_r <= src_nxt;
			tctl_r <= tctl_nxt;
			tctl_act_r <= tctl_act_nxt;
			tie_r <= tie_nxt;
			thalt_r <= thalt_nxt;
			cctl_r <= cctl_nxt;
			cnt_wr_r <= cnt_wr_nxt;
			lim_wr_r <= lim_wr_nxt;
			lim_act_r <= lim_act_nxt;
			match_r <= match_nxt;
			ien_r <= ien_nxt;
			ist_r <= ist_nxt;
			cp_r <= cp_nxt;
			lp_r <= lp_nxt;
			tp_r <= tp_nxt;
			cc_r <= cc_nxt;
			lc_r <= lc_nxt;
			tc_r <= tc_nxt;
			cnt_r <= cnt_nxt;
			pre_r <= pre_nxt;
			ppm_r <= ppm_nxt;
			corr_r <= corr_nxt;
			aw_h_r <= aw_h_nxt;
			w_h_r <= w_h_nxt;
			awi_r <= awi_nxt;
			wd_r <= wd_nxt;
			wb_r <= wb_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
		end
	end
endmodule : rcpt_top

// File: tb/rcpt_top_sva.sv
// bus and interrupt assertions for the rcpt top
`timescale 1ns/1ps
module rcpt_top_sva (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// interrupts
	input wire logic tick_irq,
	input wire logic irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped early");
	a_read_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	a_wr_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	a_rd_refused: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	a_byte_lane: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("read data outside byte lane");
	a_tick_in_irq: assert property (tick_irq |-> irq)
		else $error("tick request without summary request");
	a_tick_clear: assert property ($fell(tick_irq) |-> bvalid || $past(bvalid))
		else $error("tick request fell without a write");
	c_tick: cover property ($rose(tick_irq));
	c_irq: cover property ($rose(irq));
	c_err: cover property (bvalid && bresp == 2'h2);
endmodule : rcpt_top_sva

bind rcpt_top rcpt_top_sva chk_u (.clock(clock), .nrst(nrst), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.tick_irq(tick_irq), .irq(irq));

// File: tb/rcpt_top_tb_top.sv
// register and event bench for the rcpt top
`timescale 1ns/1ps
module rcpt_top_tb_top;
	import rcpt_pkg::*;
	typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] rd; logic [1:0] rs;} rcpt_row_t;
	logic clock = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cpu_halted = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, tick_irq, irq;
	logic [3:0] src = 4'h0;
	// no wrap, so every source level keeps its full length
	int ph = 0;
	int n_fail = 0, checked = 0, i;
	rcpt_row_t rows[10] = '{'{6'h05, 8'h01, 8'h01, 2'h0}, '{6'h06, 8'hff, 8'hff, 2'h0},
		'{6'h07, 8'h01, 8'h01, 2'h0}, '{6'h07, 8'h02, 8'h02, 2'h0}, '{6'h07, 8'h03, 8'h03, 2'h0},
		'{6'h07, 8'h00, 8'h00, 2'h0}, '{6'h0c, 8'h5a, 8'h5a, 2'h0}, '{6'h0d, 8'ha5, 8'ha5, 2'h0},
		'{6'h15, 8'h01, 8'h01, 2'h0}, '{6'h3f, 8'h01, 8'h00, 2'h2}};
	logic [5:0] rst_idx[14] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h10,
		6'h11, 6'h12, 6'h13, 6'h15};
	rcpt_top dut_u (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .internal_32k_osc(src[0]),
		.internal_1k_tap(src[1]), .crystal_32k_source(src[2]), .external_clock_pin(src[3]),
		.cpu_halted(cpu_halted), .tick_irq(tick_irq), .irq(irq));
	always #20 clock = ~clock;
	// four unrelated source rates, each level held at least three cycles
	always @(posedge clock) begin
		ph <= ph + 1;
		if (ph % 3 == 0) src[0] <= ~src[0];
		if (ph % 5 == 0) src[1] <= ~src[1];
		if (ph % 4 == 0) src[2] <= ~src[2];
		if (ph % 7 == 0) src[3] <= ~src[3];
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		@(posedge clock);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] idx, output logic [31:0] d);
		@(posedge clock);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = {rresp, rdata[29:0]};
		rready <= 1'b0;
	endtask : rd
	task automatic rchk(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		rd(idx, d);
		chk(d, {er, 22'h0, e});
	endtask : rchk
	// polls a busy bit; gives up after a bounded number of reads
	task automatic wait_idle(input logic [5:0] idx, input logic [7:0] m);
		logic [31:0] d;
		for (int k = 0; k < 40; k++) begin
			rd(idx, d);
			if ((d[7:0] & m) == 8'h00) break;
		end
		chk({24'h000000, d[7:0] & m}, 32'h0);
	endtask : wait_idle
	task automatic wait_pin(input int which);
		for (int k = 0; k < 600 && !(which ? irq : tick_irq); k++)
			@(posedge clock);
	endtask : wait_pin
	initial begin
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		foreach (rst_idx[j]) rchk(rst_idx[j], rst_idx[j] inside {6'h0a, 6'h0b} ? 8'hff : 8'h00, 2'h0);
		for (i = 0; i < 10; i++) begin
			wr(rows[i].idx, rows[i].wd);
			chk({30'h0, bresp}, {30'h0, rows[i].rs});
			rchk(rows[i].idx, rows[i].rd, rows[i].rs);
		end
		wr(6'h15, 8'h00);
		// count write lands only after the crossing
		wr(6'h08, 8'h02);
		rchk(6'h19, 8'h02, 2'h0);
		wait_idle(6'h19, 8'h02);
		rchk(6'h08, 8'h02, 2'h0);
		wr(6'h0a, 8'h03);
		rchk(6'h19, 8'h04, 2'h0);
		wait_idle(6'h19, 8'h04);
		wr(6'h0b, 8'h00);
		wait_idle(6'h19, 8'h04);
		wr(6'h1c, 8'h01);
		wr(6'h18, 8'h01);
		wait_pin(1);
		chk({31'h0, irq}, 32'h1);
		rchk(6'h1a, 8'h01, 2'h0);
		wr(6'h18, 8'h00);
		repeat (60) @(posedge clock);
		wr(6'h1b, 8'h01);
		@(posedge clock);
		chk({31'h0, irq}, 32'h0);
		// tick held off by debug halt, then released
		wr(6'h12, 8'h01);
		cpu_halted <= 1'b1;
		wr(6'h10, 8'h09);
		rchk(6'h11, 8'h01, 2'h0);
		repeat (300) @(posedge clock);
		chk({31'h0, tick_irq}, 32'h0);
		cpu_halted <= 1'b0;
		wait_pin(0);
		chk({31'h0, tick_irq}, 32'h1);
		rchk(6'h13, 8'h01, 2'h0);
		wr(6'h12, 8'h00);
		@(posedge clock);
		chk({31'h0, tick_irq}, 32'h0);
		wr(6'h10, 8'h08);
		wait_idle(6'h11, 8'h01);
		wr(6'h13, 8'h01);
		repeat (200) @(posedge clock);
		rchk(6'h13, 8'h00, 2'h0);
		// second reset in mid-run restores limit and count
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		rchk(6'h0b, 8'hff, 2'h0);
		rchk(6'h08, 8'h00, 2'h0);
		complete_run();
	end
	initial begin
		repeat (30000) @(posedge clock);
		n_fail++;
		complete_run();
	end
endmodule : rcpt_top_tb_top
